//--- hdl/ssp_consts.svh
// Summary of operation
// - Accept traffic only on select code 010
// - Frame starts with 14-bit reference divider, MSB first
// - Then 10-bit main divider, MSB first
// - Then 7-bit swallow counter, MSB first
// - Last bit is control bit, sent as written to the frame register, high or low
// - Latch dividers only when control bit is one
// - Locked: flag high, lamp off; else reverse
// - Controller checks lock flag after each frame
// - Data sampled on serial clock rising edge
// - Enable high copies shift register to latches
// - Gate enable, clock, data only on address match
// - Lock detect high when divided signals in phase
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_FRAME_BITS 32
`define SSP_REF_W 14
`define SSP_MAIN_W 10
`define SSP_SWAL_W 7
`define SSP_REF_POS 18
`define SSP_MAIN_POS 8
`define SSP_SWAL_POS 1
`define SSP_CTRL_POS 0
`define SSP_SELECT_CODE 3'h2
`define SSP_DIV_HALF 8
`define SSP_EN_CYCLES 4
`define SSP_REG_CMD_LO 12'h000
`define SSP_REG_CMD_HI 12'h004
`define SSP_REG_STATUS 12'h008
`define SSP_REG_IRQ_STAT 12'h00c
`define SSP_REG_IRQ_MASK 12'h010
`define SSP_REG_DIVS 12'h014
`endif

//--- hdl/ssp_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.svh"
module ssp_ctrl #(
   parameter int DIV_HALF = `SSP_DIV_HALF,
   parameter int EN_CYCLES = `SSP_EN_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   ssp_link_if.ctrl link,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import ssp_pkg::*;
   localparam int EN_LEN = EN_CYCLES * DIV_HALF;
   ssp_state_t state_r;
   logic [`SSP_FRAME_BITS-1:0] frame_r;
   logic [2:0] sel_r;
   logic [5:0] bit_r;
   logic [4:0] div_r;
   logic [5:0] en_r;
   logic sclk_r, sdat_r, sen_r, busy_r, done_ev;
   logic l0, l1, lock_d_r;
   logic [1:0] ist_r, imask_r;
   logic [31:0] rd_r;
   logic rdy_r, err_r, irq_r;
   wire logic acc = psel & penable & ~rdy_r;
   wire logic wr = acc & pwrite;
   wire logic rd = acc & ~pwrite;
   wire logic idle = (state_r == SSP_IDLE);
   wire logic go = wr && paddr == `SSP_REG_CMD_HI && idle;
   // ==========================================
   // Parameter checks
   if (DIV_HALF < 1 || DIV_HALF > 32) begin : g_bad_div
      $error("ssp_ctrl: DIV_HALF must lie in 1..32");
   end
   if (EN_LEN < 1 || EN_LEN > 63) begin : g_bad_en
      $error("ssp_ctrl: EN_CYCLES * DIV_HALF must lie in 1..63");
   end
   // ==========================================
   // Register decode
   function automatic logic reg_known(input logic [11:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         `SSP_REG_CMD_LO, `SSP_REG_CMD_HI, `SSP_REG_STATUS: hit = 1'b1;
         `SSP_REG_IRQ_STAT, `SSP_REG_IRQ_MASK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction
   // ==========================================
   // APB handshake: one wait state, ready for one cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdy_r <= 1'b0;
      end else begin
         rdy_r <= acc;
      end
   end
   // ==========================================
   // Register writes; frame and select hold while a frame is out
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         frame_r <= '0;
         sel_r <= `SSP_SELECT_CODE;
         imask_r <= 2'h0;
      end else if (wr) begin
         case (paddr)
            `SSP_REG_CMD_LO: begin
               if (idle) begin
                  frame_r <= pwdata;
               end
            end
            `SSP_REG_CMD_HI: begin
               if (idle) begin
                  sel_r <= pwdata[2:0];
               end
            end
            `SSP_REG_IRQ_MASK: imask_r <= pwdata[1:0];
            default: begin
            end
         endcase
      end
   end
   // ==========================================
   // Read data, shown with ready
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_r <= 32'h0;
      end else if (rd) begin
         case (paddr)
            `SSP_REG_CMD_LO: rd_r <= frame_r;
            `SSP_REG_CMD_HI: rd_r <= {29'h0, sel_r};
            `SSP_REG_STATUS: rd_r <= {30'h0, busy_r, l1};
            `SSP_REG_IRQ_STAT: rd_r <= {30'h0, ist_r};
            `SSP_REG_IRQ_MASK: rd_r <= {30'h0, imask_r};
            default: rd_r <= 32'h0;
         endcase
      end
   end
   // ==========================================
   // Error response for unmapped addresses
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         err_r <= 1'b0;
      end else begin
         err_r <= acc && !reg_known(paddr);
      end
   end
   // ==========================================
   // Lock flag synchroniser
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         l0 <= 1'b0;
         l1 <= 1'b0;
         lock_d_r <= 1'b0;
      end else begin
         l0 <= link.lock_flag;
         l1 <= l0;
         lock_d_r <= l1;
      end
   end
   // ==========================================
   // Interrupts: bit0 frame done, bit1 lock change
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ist_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         if (rd && paddr == `SSP_REG_IRQ_STAT) begin
            ist_r <= {l1 ^ lock_d_r, done_ev};
         end else begin
            ist_r <= ist_r | {l1 ^ lock_d_r, done_ev};
         end
         irq_r <= |(ist_r & imask_r);
      end
   end
   // ==========================================
   // Serial sender
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= SSP_IDLE;
         bit_r <= 6'h0;
         div_r <= 5'h0;
         en_r <= 6'h0;
         sclk_r <= 1'b0;
         sdat_r <= 1'b0;
         sen_r <= 1'b0;
         busy_r <= 1'b0;
         done_ev <= 1'b0;
      end else begin
         done_ev <= 1'b0;
         case (state_r)
            SSP_IDLE: begin
               if (go) begin
                  state_r <= SSP_SHIFT;
                  busy_r <= 1'b1;
                  bit_r <= 6'h0;
                  div_r <= 5'h0;
                  sdat_r <= frame_r[`SSP_FRAME_BITS-1];
               end
            end
            SSP_SHIFT: begin
               if (div_r == 5'(DIV_HALF - 1)) begin
                  div_r <= 5'h0;
                  sclk_r <= ~sclk_r;
                  if (sclk_r) begin
                     if (bit_r == 6'(`SSP_FRAME_BITS - 1)) begin
                        state_r <= SSP_LATCH;
                        en_r <= 6'h0;
                        sen_r <= 1'b1;
                     end else begin
                        bit_r <= bit_r + 6'h1;
                        sdat_r <= frame_r[5'(`SSP_FRAME_BITS - 2) - bit_r[4:0]];
                     end
                  end
               end else begin
                  div_r <= div_r + 5'h1;
               end
            end
            SSP_LATCH: begin
               if (en_r == 6'(EN_LEN)) begin
                  sen_r <= 1'b0;
                  busy_r <= 1'b0;
                  done_ev <= 1'b1;
                  state_r <= SSP_IDLE;
               end else begin
                  en_r <= en_r + 6'h1;
               end
            end
            default: state_r <= SSP_IDLE;
         endcase
      end
   end
   // ==========================================
   // Outputs
   assign link.select_code = sel_r;
   assign link.ser_clk = sclk_r;
   assign link.ser_data = sdat_r;
   assign link.ser_enable = sen_r;
   assign prdata = rd_r;
   assign pready = rdy_r;
   assign pslverr = err_r;
   assign irq = irq_r;
endmodule
`default_nettype wire

//--- hdl/ssp_device.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.svh"
module ssp_device (
   input wire logic core_clk,
   input wire logic rstn,
   ssp_link_if.dev link,
   input wire logic phase_lock_detect,
   output logic [`SSP_REF_W-1:0] ref_div,
   output logic [`SSP_MAIN_W-1:0] main_div,
   output logic [`SSP_SWAL_W-1:0] swallow_cnt,
   output logic fault_lamp,
   output logic load_pulse
);
   import ssp_pkg::*;
   // ==========================================
   // Input synchronisers
   logic [2:0] s0_sel, s1_sel;
   logic [2:0] s0_pin, s1_pin;
   logic s0_lock, s1_lock, clk_d_r;
   logic [`SSP_FRAME_BITS-1:0] shift_r;
   logic [`SSP_REF_W-1:0] ref_r;
   logic [`SSP_MAIN_W-1:0] main_r;
   logic [`SSP_SWAL_W-1:0] swal_r;
   logic flag_r, lamp_r, load_r, en_d_r;
   wire logic match = (s1_sel == `SSP_SELECT_CODE);
   wire logic g_clk = match & s1_pin[0];
   wire logic g_dat = match & s1_pin[1];
   wire logic g_en = match & s1_pin[2];
   function automatic logic edge_up(input logic now_v, input logic was_v);
      return now_v & ~was_v;
   endfunction
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s0_sel <= 3'h0;
         s1_sel <= 3'h0;
         s0_pin <= 3'h0;
         s1_pin <= 3'h0;
         s0_lock <= 1'b0;
         s1_lock <= 1'b0;
      end else begin
         s0_sel <= link.select_code;
         s1_sel <= s0_sel;
         s0_pin <= {link.ser_enable, link.ser_data, link.ser_clk};
         s1_pin <= s0_pin;
         s0_lock <= phase_lock_detect;
         s1_lock <= s0_lock;
      end
   end
   // ==========================================
   // Shift register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_d_r <= 1'b0;
         shift_r <= '0;
      end else begin
         clk_d_r <= g_clk;
         if (edge_up(g_clk, clk_d_r)) begin
            shift_r <= {shift_r[`SSP_FRAME_BITS-2:0], g_dat};
         end
      end
   end
   // ==========================================
   // Divider latches
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         en_d_r <= 1'b0;
         ref_r <= '0;
         main_r <= '0;
         swal_r <= '0;
         load_r <= 1'b0;
      end else begin
         en_d_r <= g_en;
         load_r <= 1'b0;
         if (edge_up(g_en, en_d_r) && shift_r[`SSP_CTRL_POS]) begin
            ref_r <= shift_r[`SSP_REF_POS +: `SSP_REF_W];
            main_r <= shift_r[`SSP_MAIN_POS +: `SSP_MAIN_W];
            swal_r <= shift_r[`SSP_SWAL_POS +: `SSP_SWAL_W];
            load_r <= 1'b1;
         end
      end
   end
   // ==========================================
   // Lock status
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag_r <= 1'b0;
         lamp_r <= 1'b1;
      end else begin
         flag_r <= s1_lock;
         lamp_r <= ~s1_lock;
      end
   end
   assign link.lock_flag = flag_r;
   assign fault_lamp = lamp_r;
   assign ref_div = ref_r;
   assign main_div = main_r;
   assign swallow_cnt = swal_r;
   assign load_pulse = load_r;
endmodule
`default_nettype wire

//--- hdl/ssp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ssp_link_if;
   import ssp_pkg::*;
   ssp_sel_t select_code;
   logic ser_clk;
   logic ser_data;
   logic ser_enable;
   logic lock_flag;
   modport ctrl (output select_code, output ser_clk, output ser_data, output ser_enable, input lock_flag);
   modport dev (input select_code, input ser_clk, input ser_data, input ser_enable, output lock_flag);
endinterface
`default_nettype wire

//--- hdl/ssp_pkg.sv
package ssp_pkg;
   typedef enum logic [1:0] {
      SSP_IDLE,
      SSP_SHIFT,
      SSP_LATCH
   } ssp_state_t;
   typedef logic [2:0] ssp_sel_t;
endpackage

//--- tb/ssp_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ssp_link_asserts (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [2:0] select_code,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic ser_enable,
   input wire logic lock_flag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // Rising serial clock edges since last enable
   logic clk_d_r;
   logic [5:0] rise_cnt_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         clk_d_r <= 1'b0;
         rise_cnt_r <= 6'h00;
      end else begin
         clk_d_r <= ser_clk;
         if (ser_enable) rise_cnt_r <= 6'h00;
         else if (ser_clk && !clk_d_r) rise_cnt_r <= rise_cnt_r + 6'h01;
      end
   end
   // ==========================================
   // Properties
   property p_sel_stable; ser_clk || ser_enable |-> $stable(select_code); endproperty
   property p_clk_high; $rose(ser_clk) |-> ser_clk [*8] ##1 !ser_clk; endproperty
   property p_clk_low; $fell(ser_clk) |-> !ser_clk [*8]; endproperty
   property p_data_stable; ser_clk |-> $stable(ser_data); endproperty
   property p_en_no_clk; ser_enable |-> !ser_clk; endproperty
   property p_en_len; $rose(ser_enable) |-> ser_enable [*8] ##[1:40] !ser_enable; endproperty
   property p_frame_bits; $rose(ser_enable) |-> rise_cnt_r == 6'h20; endproperty
   property p_cnt_max; rise_cnt_r <= 6'h20; endproperty
   a_sel_stable: assert property (p_sel_stable) else $error("select code moved in frame");
   a_clk_high: assert property (p_clk_high) else $error("serial clock high time wrong");
   a_clk_low: assert property (p_clk_low) else $error("serial clock low time wrong");
   a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");
   a_en_no_clk: assert property (p_en_no_clk) else $error("clock high during enable");
   a_en_len: assert property (p_en_len) else $error("enable pulse length wrong");
   a_frame_bits: assert property (p_frame_bits) else $error("frame not 32 bits");
   a_cnt_max: assert property (p_cnt_max) else $error("too many bits before enable");
   c_load: cover property ($rose(ser_enable));
   c_lock: cover property ($rose(lock_flag));
   c_unlock: cover property ($fell(lock_flag));
endmodule
`default_nettype wire

//--- tb/synth_serial_program_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ssp_consts.svh"
module synth_serial_program_port_tb;
   import ssp_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pld = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, load_pulse, fault_lamp, er;
   logic [13:0] ref_div;
   logic [9:0] main_div;
   logic [6:0] swallow_cnt;
   int fail_count = 0, checks_done = 0, loads = 0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (load_pulse === 1'b1) loads++;
   ssp_link_if link ();
   ssp_ctrl ssp_ctrl_i (.core_clk(core_clk), .rstn(rstn), .link(link), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   ssp_device ssp_device_i (.core_clk(core_clk), .rstn(rstn), .link(link), .phase_lock_detect(pld),
      .ref_div(ref_div), .main_div(main_div), .swallow_cnt(swallow_cnt), .fault_lamp(fault_lamp),
      .load_pulse(load_pulse));
   ssp_link_asserts ssp_link_asserts_i (.core_clk(core_clk), .rstn(rstn), .select_code(link.select_code),
      .ser_clk(link.ser_clk), .ser_data(link.ser_data), .ser_enable(link.ser_enable), .lock_flag(link.lock_flag));
   // ==========================================
   // Shared tasks
   task end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk) begin psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge core_clk) penable <= 1'b1;
      n = 0;
      do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin fail_count++; end_sim(); end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task send(input logic [2:0] s, input logic [31:0] w);
      int n;
      apb(1'b1, `SSP_REG_CMD_LO, w);
      apb(1'b1, `SSP_REG_CMD_HI, {29'h0, s});
      n = 0;
      do begin apb(1'b0, `SSP_REG_STATUS, 32'h0); n++; end while (rd[1] !== 1'b0 && n < 400);
      if (n >= 400) begin fail_count++; end_sim(); end
   endtask
   task chk_divs(input logic [30:0] f, input int ld);
      chk("ref_div", 32'(ref_div), 32'(f[30:17]));
      chk("main_div", 32'(main_div), 32'(f[16:7]));
      chk("swallow", 32'(swallow_cnt), 32'(f[6:0]));
      chk("loads", loads, ld);
   endtask
   task wait_lock(input logic v);
      for (int i = 0; i < 50 && link.lock_flag !== v; i++) @(posedge core_clk);
      chk("lock_flag", 32'(link.lock_flag), 32'(v));
      chk("fault_lamp", 32'(fault_lamp), 32'(!v));
      if (link.lock_flag !== v) end_sim();
   endtask
   // ==========================================
   // Scenarios
   task t_load();
      apb(1'b1, `SSP_REG_IRQ_MASK, 32'h1);
      send(3'h2, {14'h2a5c, 10'h2d3, 7'h4b, 1'b1});
      chk_divs({14'h2a5c, 10'h2d3, 7'h4b}, 1);
      apb(1'b0, `SSP_REG_CMD_LO, 32'h0);
      chk("frame_rd", rd, {14'h2a5c, 10'h2d3, 7'h4b, 1'b1});
      apb(1'b0, `SSP_REG_CMD_HI, 32'h0);
      chk("sel_rd", rd, 32'h2);
      chk("irq", 32'(irq), 32'h1);
      apb(1'b0, `SSP_REG_IRQ_STAT, 32'h0);
      chk("irq_stat", rd & 32'h1, 32'h1);
      repeat (2) @(posedge core_clk);
      chk("irq_clr", 32'(irq), 32'h0);
   endtask
   task t_refuse();
      for (int s = 0; s < 8; s++) if (s != 2) send(3'(s), 32'h5555_5555);
      chk_divs({14'h2a5c, 10'h2d3, 7'h4b}, 1);
      send(3'h2, {14'h1111, 10'h0f0, 7'h33, 1'b0});
      chk_divs({14'h2a5c, 10'h2d3, 7'h4b}, 1);
   endtask
   task t_lock();
      apb(1'b0, `SSP_REG_IRQ_STAT, 32'h0);
      pld <= 1'b1;
      wait_lock(1'b1);
      apb(1'b0, `SSP_REG_STATUS, 32'h0);
      chk("status_lock", rd & 32'h1, 32'h1);
      chk("irq_masked", 32'(irq), 32'h0);
      apb(1'b0, `SSP_REG_IRQ_STAT, 32'h0);
      chk("lock_chg", rd & 32'h2, 32'h2);
      apb(1'b1, `SSP_REG_IRQ_MASK, 32'h2);
      apb(1'b0, `SSP_REG_IRQ_MASK, 32'h0);
      chk("mask_rd", rd, 32'h2);
      pld <= 1'b0;
      wait_lock(1'b0);
      repeat (6) @(posedge core_clk);
      chk("irq_unlock", 32'(irq), 32'h1);
      apb(1'b0, 12'h0ff, 32'h0);
      chk("unmapped_err", 32'(er), 32'h1);
      chk("unmapped_data", rd, 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      chk("lamp_reset", 32'(fault_lamp), 32'h1);
      chk("flag_reset", 32'(link.lock_flag), 32'h0);
      t_load();
      t_refuse();
      t_lock();
      end_sim();
   end
endmodule
`default_nettype wire
